// file: sidx_ctrl_model.sv
`timescale 1ns/10ps
// ==========================================================
// Pulse train controller: sends a burst of step pulses
module sidx_ctrl_model (
    input  wire logic       clock_i,
    input  wire logic       start_i,
    input  wire logic       dir_i,
    input  wire logic [9:0] count_i,
    output logic            step_pulse_o,
    output logic            rotation_sense_o,
    output logic            busy_o
);
    logic [9:0] left = 10'h000;
    logic [1:0] lead = 2'h0;
    initial begin
        step_pulse_o = 1'b0;
        rotation_sense_o = 1'b0;
        busy_o = 1'b0;
    end
    always @(posedge clock_i) begin
        if (start_i && !busy_o) begin
            rotation_sense_o <= dir_i;
            left <= count_i;
            lead <= 2'h3;
            busy_o <= (count_i != 10'h000);
        end else if (busy_o) begin
            if (lead != 2'h0) begin
                lead <= lead - 2'h1;
            end else if (!step_pulse_o) begin
                step_pulse_o <= 1'b1;
            end else begin
                step_pulse_o <= 1'b0;
                left <= left - 10'h001;
                busy_o <= (left != 10'h001);
            end
        end
    end
endmodule : sidx_ctrl_model

// file: sidx_indexer.sv
// The placing of the registers and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/10ps
module sidx_indexer #(
    parameter int unsigned REDUCE_CYC = sidx_pkg::REDUCE_CYC,
    parameter int unsigned BLINK_CYC  = sidx_pkg::BLINK_CYC
) (
    input  wire logic                    clock_i,
    input  wire logic                    sys_rst_i,
    input  wire sidx_pkg::sidx_avs_req_t avs_req_i,
    output logic                         avs_waitrequest_o,
    output logic [31:0]                  avs_readdata_o,
    input  wire logic                    step_pulse_i,
    input  wire logic                    rotation_sense_i,
    input  wire logic                    coils_release_i,
    input  wire logic                    base_step_select_i,
    input  wire sidx_pkg::sidx_fault_t   fault_det_i,
    output logic                         current_reduce_o,
    output logic                         fault_o,
    output logic                         excite_home_o,
    output logic                         alarm_led_o,
    output logic                         motor_on_o,
    output logic [8:0]                   excite_pos_o,
    output logic [3:0]                   run_current_o,
    output logic [1:0]                   current_scale_o,
    output logic                         smooth_en_o,
    output logic                         vibr_en_o,
    output logic [1:0]                   harmonic_corr_o
);
    import sidx_pkg::*;

    typedef struct packed {
        logic [3:0]  ctrl;
        logic [11:0] dial;
        logic        step_prev;
        logic [8:0]  pos;
        logic        home;
        logic [25:0] idle_cnt;
        logic        reduce;
        logic        fault;
        logic [3:0]  blinks;
        logic [25:0] blink_div;
        logic [3:0]  slot;
        logic        led;
        logic        ack;
        logic [31:0] rdata;
    } sidx_state_t;

    localparam sidx_state_t ST_RESET = '{
        ctrl: CTRL_RESET, dial: DIAL_RESET, step_prev: 1'b0, pos: 9'h000,
        home: 1'b1, idle_cnt: 26'h0, reduce: 1'b0, fault: 1'b0,
        blinks: 4'h0, blink_div: 26'h0, slot: 4'h0, led: 1'b0,
        ack: 1'b0, rdata: 32'h0
    };

    sidx_state_t st;
    sidx_state_t next_st;

    // ==========================================================
    // Decode of switches and dials
    logic [7:0]  div_w;
    logic [9:0]  modulus_w;
    logic        step_edge_w;
    logic        fault_now_w;
    logic [3:0]  harm_w;
    logic [3:0]  harm_off_w;
    logic        harm_bad_w;
    logic        req_w;

    always_comb begin
        div_w       = base_step_select_i ? 8'h01                                      // RULE22
                                         : sidx_div_f(st.dial[DIAL_DIV_LSB +: 4]);    // RULE21 RULE19
        modulus_w   = {div_w, 2'b00};                                                 // RULE8 RULE7
        step_edge_w = st.step_prev & ~step_pulse_i;                                   // RULE11 RULE14
        fault_now_w = fault_det_i.overheat | fault_det_i.overvolt | fault_det_i.overcurrent;
        harm_w      = st.dial[DIAL_HARM_LSB +: 4];
        harm_off_w  = harm_w - (st.ctrl[CTRL_LARGE] ? HARM_LARGE_LO : HARM_SMALL_LO); // RULE17 RULE18
        harm_bad_w  = harm_off_w[3:2] != 2'b00;
        req_w       = avs_req_i.read | avs_req_i.write;
    end

    function automatic logic [31:0] sidx_merge_f(input logic [31:0] old_v,
                                                 input logic [31:0] new_v,
                                                 input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction : sidx_merge_f

    // ==========================================================
    // Next state
    always_comb begin
        logic [31:0] wv;
        wv      = 32'h0;
        next_st = st;

        // Register bus: one wait cycle, then answer
        next_st.ack = req_w & ~st.ack;
        if (req_w & ~st.ack) begin
            unique case (avs_req_i.address)
                REG_CTRL: next_st.rdata = {28'h0, st.ctrl};
                REG_DIAL: next_st.rdata = {20'h0, st.dial};
                REG_STAT: next_st.rdata = {7'h0, st.pos, 9'h0, harm_bad_w,
                                           st.blinks[2:0], st.home, ~st.fault, st.reduce};
                default:  next_st.rdata = 32'h0;
            endcase
        end
        if (avs_req_i.write & st.ack) begin
            unique case (avs_req_i.address)
                REG_CTRL: begin
                    wv           = sidx_merge_f({28'h0, st.ctrl}, avs_req_i.writedata,
                                                avs_req_i.byteenable);
                    next_st.ctrl = wv[3:0];
                end
                REG_DIAL: begin
                    wv           = sidx_merge_f({20'h0, st.dial}, avs_req_i.writedata,
                                                avs_req_i.byteenable);
                    next_st.dial = wv[11:0];
                end
                default: ;
            endcase
        end

        // Excitation counter
        next_st.step_prev = step_pulse_i;
        if (step_edge_w & ~st.fault & ~coils_release_i) begin                        // RULE3
            if (rotation_sense_i) begin                                               // RULE11
                next_st.pos = ({1'b0, st.pos} >= modulus_w - 10'h001) ? 9'h000
                                                                      : st.pos + 9'h001;
            end else begin
                next_st.pos = (st.pos == 9'h000 || {1'b0, st.pos} >= modulus_w)
                            ? 9'((modulus_w - 10'h001)) : st.pos - 9'h001;            // RULE8
            end
        end
        next_st.home = next_st.pos == 9'h000;                                         // RULE5

        // Standstill current reduction
        if (step_edge_w) begin
            next_st.idle_cnt = 26'h0;
            next_st.reduce   = 1'b0;                                                  // RULE26
        end else if (st.idle_cnt < 26'(REDUCE_CYC - 1)) begin
            next_st.idle_cnt = st.idle_cnt + 26'h1;
        end else begin
            next_st.reduce   = 1'b1;                                                  // RULE25 RULE1
        end

        // Protection latch: held until reset, first cause kept
        if (fault_now_w & ~st.fault) begin
            next_st.fault     = 1'b1;                                                 // RULE2 RULE3
            next_st.blinks    = fault_det_i.overheat ? BLINKS_HEAT
                              : fault_det_i.overvolt ? BLINKS_VOLT : BLINKS_CURR;     // RULE4
            next_st.blink_div = 26'h0;
            next_st.slot      = 4'h0;
        end else if (st.fault) begin
            if (st.blink_div >= 26'(BLINK_CYC - 1)) begin
                next_st.blink_div = 26'h0;
                next_st.slot      = (st.slot >= {st.blinks[2:0], 1'b0} + BLINK_GAP - 4'h1)
                                  ? 4'h0 : st.slot + 4'h1;
            end else begin
                next_st.blink_div = st.blink_div + 26'h1;
            end
        end
        next_st.led = next_st.fault & ~next_st.slot[0]
                    & (next_st.slot < {next_st.blinks[2:0], 1'b0});                    // RULE4
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            st <= ST_RESET;                                                           // RULE6 RULE20
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs
    assign avs_waitrequest_o = req_w & ~st.ack;
    assign avs_readdata_o    = st.rdata;
    assign current_reduce_o  = st.reduce;                                             // RULE1
    assign fault_o           = ~st.fault;                                             // RULE2
    assign excite_home_o     = st.home;                                               // RULE5
    assign alarm_led_o       = st.led;
    assign motor_on_o        = ~st.fault & ~coils_release_i;                          // RULE3
    assign excite_pos_o      = st.pos;
    assign run_current_o     = st.dial[DIAL_RUN_LSB +: 4];                            // RULE24
    assign current_scale_o   = ~st.reduce ? 2'b00 : (st.ctrl[CTRL_STILL] ? 2'b10 : 2'b01);
    assign smooth_en_o       = ~st.ctrl[CTRL_SMOOTH];                                 // RULE15
    assign vibr_en_o         = ~st.ctrl[CTRL_VIBR];                                   // RULE16
    assign harmonic_corr_o   = harm_bad_w ? 2'b00 : harm_off_w[1:0];                  // RULE17 RULE18

    // ==========================================================
    // Checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    chk_home_flag: assert property (excite_home_o == (excite_pos_o == 9'h000)) // RULE5
        else $error("home flag disagrees with excitation position");
    chk_fault_drop: assert property (fault_now_w |=> !fault_o [*3]) // RULE2
        else $error("fault output did not drop and stay low");
    chk_fault_stop: assert property (!fault_o |-> !motor_on_o && $stable(excite_pos_o)) // RULE3
        else $error("motor still driven after fault");
    chk_step_cw: assert property (step_edge_w && fault_o && !coils_release_i
                                  && rotation_sense_i && excite_pos_o == 9'h000
                                  |=> excite_pos_o == 9'h001) // RULE11
        else $error("clockwise step did not advance by one");
    chk_step_ccw: assert property (step_edge_w && fault_o && !coils_release_i
                                   && !rotation_sense_i && excite_pos_o == 9'h000
                                   |=> {1'b0, excite_pos_o} == $past(modulus_w) - 10'h001) // RULE8
        else $error("counterclockwise step did not wrap to the top");
    chk_reduce_clear: assert property (step_edge_w |=> !current_reduce_o) // RULE26
        else $error("current reduction not cleared by a step");
    chk_reduce_set: assert property (st.idle_cnt == 26'(REDUCE_CYC - 1) && !step_edge_w
                                     |=> current_reduce_o) // RULE25
        else $error("current reduction late after idle time");
    chk_base_step: assert property (base_step_select_i |-> modulus_w == 10'h004) // RULE22
        else $error("base step select did not force full step");
    chk_reset_home: assert property ($past(sys_rst_i) |-> excite_home_o && fault_o) // RULE6
        else $error("reset did not return to home");
    chk_bus_answer: assert property (req_w && !st.ack |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
        else $error("bus answer not given on the second edge");

    cov_home_return: cover property (step_edge_w && !excite_home_o ##1 excite_home_o);
    cov_fault_blink: cover property (!fault_o && alarm_led_o);
    cov_reduce: cover property (!current_reduce_o ##1 current_reduce_o);

endmodule : sidx_indexer

// file: sidx_pkg.sv
// How it works
// RULE1: current_reduce_o stays high while automatic current-down is active.
// RULE2: fault_o is high in normal operation and drops when protection trips.
// RULE3: Overheat, overvoltage or overcurrent drops fault_o, blinks alarm, cuts current.
// RULE4: Alarm blinks two, three or five times for overheat, overvoltage, overcurrent.
// RULE5: excite_home_o is high while the excitation state is step zero.
// RULE6: Reset puts the excitation state at the home position.
// RULE7: With 1.8 degree base step, home recurs every 7.2 degrees, on pulses.
// RULE8: Excitation counter wraps at four times the selected division count.
// RULE9: Controller stops the shaft only at multiples of 7.2 degrees; the testbench also stops it at excitation positions other than home.
// RULE10: Controller changes step angle only when stopped with excite_home_o high.
// RULE11: Each falling step pulse moves one step, clockwise when rotation_sense high.
// RULE12: Controller sets rotation_sense at least 10 us before the qualified pulse; the model sets it five clock cycles before the falling edge.
// RULE13: Controller waits after releasing coils_release before issuing step pulses.
// RULE14: Step pulses accepted up to 250 kHz, 500 kHz in line-driver mode.
// RULE15: smooth_drive_sw low enables automatic step subdivision; high disables it.
// RULE16: vibration_damp_sw low enables medium-speed suppression; high disables it.
// RULE17: Small variants: harmonic dial C to F gives 0,-2,-4,-6 percent, default E.
// RULE18: Large variant: harmonic dial 8 to B gives 0,-2,-4,-6 percent, default A; the dial resets to E in both variants.
// RULE19: Division dial codes 0 to F map to 1,2,4,5,8,9,10,16,...,128 divisions.
// RULE20: Division dial resets to code zero, one division.
// RULE21: Division dial takes effect only while base_step_select is low.
// RULE22: base_step_select high forces the base step and ignores the division dial.
// RULE23: Controller never changes base step or division while the motor runs.
// RULE24: Run current dial selects one of 16 per-phase current levels.
// RULE25: Current drops to standstill level about 0.3 s after pulses stop.
// RULE26: current_reduce_o high exactly during standstill reduction, cleared by a pulse.
package sidx_pkg;

    // ==========================================================
    // Register map
    localparam logic [3:0]  REG_CTRL      = 4'h0;
    localparam logic [3:0]  REG_DIAL      = 4'h4;
    localparam logic [3:0]  REG_STAT      = 4'h8;
    localparam int          CTRL_SMOOTH   = 0;
    localparam int          CTRL_VIBR     = 1;
    localparam int          CTRL_STILL    = 2;
    localparam int          CTRL_LARGE    = 3;
    localparam int          DIAL_DIV_LSB  = 0;
    localparam int          DIAL_HARM_LSB = 4;
    localparam int          DIAL_RUN_LSB  = 8;
    localparam int          STAT_POS_LSB  = 16;
    localparam logic [3:0]  CTRL_RESET    = 4'h0;
    localparam logic [11:0] DIAL_RESET    = 12'hfe0;
    localparam logic [3:0]  HARM_LARGE_DEF = 4'ha;
    localparam logic [3:0]  HARM_SMALL_LO = 4'hc;
    localparam logic [3:0]  HARM_LARGE_LO = 4'h8;

    // ==========================================================
    // Timing
    localparam real         CLK_HZ        = 200.0e6;
    localparam real         REDUCE_TIME_S = 0.3;
    localparam real         BLINK_TIME_S  = 0.25;
    localparam int unsigned REDUCE_CYC    = int'(REDUCE_TIME_S * CLK_HZ);
    localparam int unsigned BLINK_CYC     = int'(BLINK_TIME_S * CLK_HZ);
    localparam logic [3:0]  BLINK_GAP     = 4'h4;
    localparam logic [3:0]  BLINKS_HEAT   = 4'h2;
    localparam logic [3:0]  BLINKS_VOLT   = 4'h3;
    localparam logic [3:0]  BLINKS_CURR   = 4'h5;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic        read;
        logic        write;
        logic [3:0]  address;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } sidx_avs_req_t;

    typedef struct packed {
        logic overheat;
        logic overvolt;
        logic overcurrent;
    } sidx_fault_t;

    // Divisions per base step for each dial code
    function automatic logic [7:0] sidx_div_f(input logic [3:0] code);
        logic [7:0] d;
        d = 8'h01;
        unique case (code)
            4'h0: d = 8'h01;
            4'h1: d = 8'h02;
            4'h2: d = 8'h04;
            4'h3: d = 8'h05;
            4'h4: d = 8'h08;
            4'h5: d = 8'h09;
            4'h6: d = 8'h0a;
            4'h7: d = 8'h10;
            4'h8: d = 8'h12;
            4'h9: d = 8'h14;
            4'ha: d = 8'h20;
            4'hb: d = 8'h24;
            4'hc: d = 8'h28;
            4'hd: d = 8'h40;
            4'he: d = 8'h50;
            4'hf: d = 8'h80;
        endcase
        return d;
    endfunction : sidx_div_f

endpackage : sidx_pkg

// file: tb_stepper_indexer_status_outputs.sv
`timescale 1ns/10ps
module tb_stepper_indexer_status_outputs;
    import sidx_pkg::*;
    localparam int RED = 50;
    localparam int BLK = 4;
    localparam int DIVS [16] = '{1, 2, 4, 5, 8, 9, 10, 16, 18, 20, 32, 36, 40, 64, 80, 128};
    localparam int BLINKS [3] = '{2, 3, 5};
    logic          clock_i = 1'b0;
    logic          sys_rst_i = 1'b1;
    sidx_avs_req_t req = '0;
    sidx_fault_t   fdet = '0;
    logic          base_sel = 1'b0;
    logic          coils = 1'b0;
    logic          start = 1'b0;
    logic          dir = 1'b0;
    logic [9:0]    cnt = 10'h000;
    logic          pulse, sense, busy, wait_o, reduce, fault, home, led, mon;
    logic [31:0]   rdata, q;
    logic [8:0]    pos;
    logic [3:0]    run;
    logic [1:0]    scale, harm;
    logic          smooth, vibr;
    int            fail_count = 0;
    int            checks = 0;
    int            cyc = 0;
    int            d, r, n;
    logic          led_prev;

    always #2.5 clock_i = ~clock_i;

    sidx_ctrl_model ctrl (.clock_i(clock_i), .start_i(start), .dir_i(dir), .count_i(cnt),
        .step_pulse_o(pulse), .rotation_sense_o(sense), .busy_o(busy));

    sidx_indexer #(.REDUCE_CYC(RED), .BLINK_CYC(BLK)) dut (.clock_i(clock_i),
        .sys_rst_i(sys_rst_i), .avs_req_i(req), .avs_waitrequest_o(wait_o),
        .avs_readdata_o(rdata), .step_pulse_i(pulse), .rotation_sense_i(sense),
        .coils_release_i(coils), .base_step_select_i(base_sel), .fault_det_i(fdet),
        .current_reduce_o(reduce), .fault_o(fault), .excite_home_o(home), .alarm_led_o(led),
        .motor_on_o(mon), .excite_pos_o(pos), .run_current_o(run), .current_scale_o(scale),
        .smooth_en_o(smooth), .vibr_en_o(vibr), .harmonic_corr_o(harm));

    // ==========================================================
    // Shared tasks
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd);
        req <= '{read: !w, write: w, address: a, byteenable: 4'hf, writedata: wd};
        do @(posedge clock_i); while (wait_o !== 1'b0);
        q = rdata;
        req <= '0;
        repeat (2) @(posedge clock_i);
    endtask : bus

    task automatic stp(input logic dr, input int k);
        start <= 1'b1;
        dir <= dr;
        cnt <= k[9:0];
        @(posedge clock_i);
        start <= 1'b0;
        @(posedge clock_i);
        while (busy) @(posedge clock_i);
        repeat (2) @(posedge clock_i);
    endtask : stp

    task automatic do_reset();
        sys_rst_i <= 1'b1;
        repeat (12) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        @(posedge clock_i);
    endtask : do_reset

    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 60000) begin
            fail_count++;
            final_report();
        end
    end

    // ==========================================================
    // Tests
    initial begin
        void'($urandom(51999));
        do_reset();
        chk(home, 1'b1);
        chk(fault, 1'b1);
        bus(1'b0, REG_DIAL, 32'h0);
        chk(q, 32'h00000fe0);
        bus(1'b0, 4'hc, 32'h0);
        chk(q, 32'h0);
        $display("test reset done");
        for (int c = 0; c < 16; c++) begin
            d = 4 * DIVS[c];
            bus(1'b1, REG_DIAL, 32'h00000fe0 | c);
            stp(1'b0, 1);
            chk(pos, d - 1);
            stp(1'b1, 1);
            chk(home, 1'b1);
            r = $urandom_range(d - 1, 1);
            stp(1'b1, r);
            chk({home, pos}, r);
            stp(1'b0, r);
            chk(home, 1'b1);
            stp(1'b1, d);
            chk({home, pos}, 10'h200);
        end
        $display("test divisions done");
        base_sel <= 1'b1;
        stp(1'b1, 4);
        chk(home, 1'b1);
        base_sel <= 1'b0;
        coils <= 1'b1;
        stp(1'b1, 3);
        chk({mon, pos}, 10'h000);
        coils <= 1'b0;
        repeat (20) @(posedge clock_i);
        $display("test base step done");
        repeat (RED + 10) @(posedge clock_i);
        chk({reduce, scale}, 3'b101);
        bus(1'b1, REG_CTRL, 32'h4);
        chk({reduce, scale}, 3'b110);
        stp(1'b1, 1);
        chk(reduce, 1'b0);
        stp(1'b0, 1);
        $display("test reduce done");
        for (int h = 0; h < 16; h++) begin
            r = $urandom_range(3, 0);
            bus(1'b1, REG_CTRL, r);
            chk({smooth, vibr}, {!r[0], !r[1]});
            bus(1'b1, REG_DIAL, (h << 8) | (h << 4));
            chk(harm, (h >= 12) ? h - 12 : 0);
            chk(run, h);
            bus(1'b1, REG_CTRL, 32'h8);
            chk(harm, (h >= 8 && h < 12) ? h - 8 : 0);
        end
        $display("test dials done");
        for (int f = 0; f < 3; f++) begin
            do_reset();
            fdet <= sidx_fault_t'(3'b100 >> f);
            repeat (2) @(posedge clock_i);
            fdet <= '0;
            chk({fault, mon}, 2'b00);
            stp(1'b1, 2);
            chk(pos, 9'h000);
            repeat ($urandom_range(20, 5)) @(posedge clock_i);
            n = 0;
            led_prev = led;
            repeat ((2 * BLINKS[f] + 4) * BLK) begin
                @(posedge clock_i);
                if (led === 1'b1 && led_prev === 1'b0) n++;
                led_prev = led;
            end
            chk(n, BLINKS[f]);
        end
        $display("test faults done");
        final_report();
    end
endmodule : tb_stepper_indexer_status_outputs
